//--- logic/sac_top.sv
`timescale 1ns/1ps

module sac_top
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [3:0] addr_in,
   input wire logic [7:0] wr_data_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic rx_pin_in,
   input wire logic internal_transmit_out_in,
   input wire logic serial_clock_source_select_in,
   input wire logic presc_bus_tick_in,
   input wire logic presc_crystal_tick_in,
   output logic [7:0] rd_data_out,
   output logic tx_pin_out,
   output logic irq_out
);

   // =========================================================================
   // Declarations
   sac_pkg::sac_ctrl_s ctrl_reg;
   sac_pkg::sac_ctrl_s ctrl_next;
   sac_pkg::sac_state_e state_reg;
   sac_pkg::sac_state_e state_next;
   logic [8:0] count_reg;
   logic [8:0] count_next;
   logic lost_reg;
   logic lost_next;
   logic fin_reg;
   logic fin_next;
   logic ovf_reg;
   logic ovf_next;
   logic [2:0] irq_stat_reg;
   logic [2:0] irq_stat_next;
   logic [2:0] irq_mask_reg;
   logic [2:0] irq_mask_next;
   logic irq_reg;
   logic irq_next;
   logic [7:0] rd_data_reg;
   logic [7:0] rd_data_next;
   logic tx_pin_reg;
   logic tx_pin_next;
   logic rx_meta_reg;
   logic rx_sync_reg;
   logic rx_prev_reg;
   logic tx_prev_reg;
   logic rx_fall;
   logic rx_rise;
   logic tx_rise;
   logic tx_fall;
   logic tick;
   logic ctrl_wr;
   logic ev_fin;
   logic ev_ovf;
   logic ev_lost;
   logic running;
   logic [8:0] sample_at;
   logic [2:0] ev_vec;

   // =========================================================================
   // Receive pin synchroniser and edge detection
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         rx_meta_reg <= 1'b1;
         rx_sync_reg <= 1'b1;
         rx_prev_reg <= 1'b1;
         tx_prev_reg <= 1'b1;
      end
      else
      begin
         rx_meta_reg <= rx_pin_in;
         rx_sync_reg <= rx_meta_reg;
         rx_prev_reg <= rx_sync_reg;
         tx_prev_reg <= internal_transmit_out_in;
      end
   end

   assign rx_fall = rx_prev_reg & ~rx_sync_reg;
   assign rx_rise = ~rx_prev_reg & rx_sync_reg;
   assign tx_rise = ~tx_prev_reg & internal_transmit_out_in;
   assign tx_fall = tx_prev_reg & ~internal_transmit_out_in;
   assign ctrl_wr = wr_in && (addr_in == sac_pkg::ADDR_CTRL);

   // =========================================================================
   // Counter clock enable
   sac_tick_gen u_tick_gen
   (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .clear_in(ctrl_wr),
      .aclk_in(ctrl_reg.aclk),
      .src_sel_in(serial_clock_source_select_in),
      .bus_tick_in(presc_bus_tick_in),
      .xtal_tick_in(presc_crystal_tick_in),
      .tick_out(tick)
   );

   // =========================================================================
   // Arbiter counter and mode sequencing
   always_comb
   begin
      ctrl_next = ctrl_reg;
      state_next = state_reg;
      count_next = count_reg;
      ev_fin = 1'b0;
      ev_ovf = 1'b0;
      ev_lost = 1'b0;
      sample_at = ctrl_reg.aclk ? sac_pkg::ARB_SAMPLE_PRESC :
                                  sac_pkg::ARB_SAMPLE_BUS;
      // Counting advances on the enable tick and wraps into the overflow flag.
      if ((state_reg == sac_pkg::SAC_ST_COUNT) && tick)
      begin
         count_next = count_reg + 9'h001;
         if (count_reg == sac_pkg::CNT_MAX)
         begin
            ev_ovf = 1'b1;
         end
      end
      case (ctrl_reg.mode)
         sac_pkg::SAC_MODE_MEASURE:
         begin
            case (state_reg)
               sac_pkg::SAC_ST_WAIT:
               begin
                  if ((!ctrl_reg.aclk && rx_fall) ||
                      (ctrl_reg.aclk && !rx_sync_reg))
                  begin
                     state_next = sac_pkg::SAC_ST_COUNT;
                     count_next = sac_pkg::CNT_ZERO;
                  end
               end
               sac_pkg::SAC_ST_COUNT:
               begin
                  if ((!ctrl_reg.aclk && rx_fall) ||
                      (ctrl_reg.aclk && rx_rise))
                  begin
                     state_next = sac_pkg::SAC_ST_DONE;
                     ev_fin = 1'b1;
                  end
               end
               sac_pkg::SAC_ST_DONE:
               begin
                  state_next = sac_pkg::SAC_ST_DONE;
               end
               default:
               begin
                  state_next = sac_pkg::SAC_ST_WAIT;
               end
            endcase
         end
         sac_pkg::SAC_MODE_ARB:
         begin
            if (tx_rise)
            begin
               state_next = sac_pkg::SAC_ST_COUNT;
               count_next = sac_pkg::CNT_ZERO;
            end
            else if (state_reg == sac_pkg::SAC_ST_COUNT)
            begin
               if (count_reg == sample_at)
               begin
                  // The line is sensed at most once per transmitted rising edge.
                  state_next = sac_pkg::SAC_ST_DONE;
                  count_next = count_reg;
                  ev_lost = !rx_sync_reg;
               end
               else if (tx_fall)
               begin
                  // Dominant transmit before any sample restarts the wait.
                  state_next = sac_pkg::SAC_ST_WAIT;
                  count_next = sac_pkg::CNT_ZERO;
               end
            end
         end
         default:
         begin
            // Idle and the reserved code hold the counter at zero.
            state_next = sac_pkg::SAC_ST_WAIT;
            count_next = sac_pkg::CNT_ZERO;
            ev_ovf = 1'b0;
         end
      endcase
      if (ctrl_wr)
      begin
         // Only mode and clock select are stored from the written byte.
         ctrl_next.mode = sac_pkg::sac_mode_e'(
            wr_data_in[sac_pkg::BIT_MODE_HI:sac_pkg::BIT_MODE_LO]);
         ctrl_next.aclk = wr_data_in[sac_pkg::BIT_ACLK];
         count_next = sac_pkg::CNT_ZERO;
         state_next = sac_pkg::SAC_ST_WAIT;
      end
   end

   assign running = (state_reg == sac_pkg::SAC_ST_COUNT) &&
                    (ctrl_reg.mode != sac_pkg::SAC_MODE_IDLE);

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         ctrl_reg <= sac_pkg::sac_ctrl_s'(3'h0);
         state_reg <= sac_pkg::SAC_ST_WAIT;
         count_reg <= sac_pkg::CNT_ZERO;
      end
      else
      begin
         ctrl_reg <= ctrl_next;
         state_reg <= state_next;
         count_reg <= count_next;
      end
   end

   // =========================================================================
   // Status flags, interrupts and transmit override
   assign ev_vec = {ev_lost, ev_ovf, ev_fin};

   always_comb
   begin
      fin_next = fin_reg;
      ovf_next = ovf_reg;
      lost_next = lost_reg;
      if (ctrl_wr)
      begin
         fin_next = 1'b0;
         ovf_next = 1'b0;
         if (!wr_data_in[sac_pkg::BIT_MODE_HI])
            lost_next = 1'b0;
      end
      // A flag event in the clearing cycle still sets the flag.
      fin_next = fin_next | ev_fin;
      ovf_next = ovf_next | ev_ovf;
      lost_next = lost_next | ev_lost;
      irq_stat_next = irq_stat_reg;
      irq_mask_next = irq_mask_reg;
      if (wr_in && (addr_in == sac_pkg::ADDR_IRQ_STATUS))
         irq_stat_next = irq_stat_reg & ~wr_data_in[2:0];
      if (wr_in && (addr_in == sac_pkg::ADDR_IRQ_MASK))
         irq_mask_next = wr_data_in[2:0];
      irq_stat_next = irq_stat_next | ev_vec;
      irq_next = |(irq_stat_next & irq_mask_next);
      tx_pin_next = internal_transmit_out_in | lost_next;
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         fin_reg <= 1'b0;
         ovf_reg <= 1'b0;
         lost_reg <= 1'b0;
         irq_stat_reg <= sac_pkg::RST_IRQ;
         irq_mask_reg <= sac_pkg::RST_IRQ;
         irq_reg <= 1'b0;
         tx_pin_reg <= 1'b1;
      end
      else
      begin
         fin_reg <= fin_next;
         ovf_reg <= ovf_next;
         lost_reg <= lost_next;
         irq_stat_reg <= irq_stat_next;
         irq_mask_reg <= irq_mask_next;
         irq_reg <= irq_next;
         tx_pin_reg <= tx_pin_next;
      end
   end

   // =========================================================================
   // Register read port
   always_comb
   begin
      rd_data_next = sac_pkg::RST_BYTE;
      if (rd_in)
      begin
         case (addr_in)
            sac_pkg::ADDR_CTRL:
            begin
               rd_data_next[sac_pkg::BIT_MODE_HI] = ctrl_reg.mode[1];
               rd_data_next[sac_pkg::BIT_MODE_LO] = ctrl_reg.mode[0];
               rd_data_next[sac_pkg::BIT_LOST] = lost_reg;
               rd_data_next[sac_pkg::BIT_ACLK] = ctrl_reg.aclk;
               rd_data_next[sac_pkg::BIT_FIN] = fin_reg;
               rd_data_next[sac_pkg::BIT_RUN] = running;
               rd_data_next[sac_pkg::BIT_OVF] = ovf_reg;
               rd_data_next[sac_pkg::BIT_MSB] = count_reg[8];
            end
            sac_pkg::ADDR_COUNT_LOW:
            begin
               rd_data_next = count_reg[7:0];
            end
            sac_pkg::ADDR_IRQ_STATUS: rd_data_next[2:0] = irq_stat_reg;
            sac_pkg::ADDR_IRQ_MASK: rd_data_next[2:0] = irq_mask_reg;
            default: rd_data_next = sac_pkg::RST_BYTE;
         endcase
      end
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         rd_data_reg <= sac_pkg::RST_BYTE;
      end
      else
      begin
         rd_data_reg <= rd_data_next;
      end
   end

   assign rd_data_out = rd_data_reg;
   assign tx_pin_out = tx_pin_reg;
   assign irq_out = irq_reg;

endmodule : sac_top

//--- logic/sac_pkg.sv
package sac_pkg;

   // ==========================================================================
   // Register map
   localparam int ADDR_W = 4;
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_COUNT_LOW = 4'h1;
   localparam logic [3:0] ADDR_IRQ_STATUS = 4'h2;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;

   // ==========================================================================
   // Control register field positions
   localparam int BIT_MODE_HI = 7;
   localparam int BIT_MODE_LO = 6;
   localparam int BIT_LOST = 5;
   localparam int BIT_ACLK = 4;
   localparam int BIT_FIN = 3;
   localparam int BIT_RUN = 2;
   localparam int BIT_OVF = 1;
   localparam int BIT_MSB = 0;

   // ==========================================================================
   // Interrupt status and mask field positions
   localparam int IRQ_W = 3;
   localparam int IRQ_FIN = 0;
   localparam int IRQ_OVF = 1;
   localparam int IRQ_LOST = 2;

   // ==========================================================================
   // Counter and timing constants
   localparam int CNT_W = 9;
   localparam logic [8:0] CNT_MAX = 9'h1FF;
   localparam logic [8:0] CNT_ZERO = 9'h000;
   localparam logic [8:0] ARB_SAMPLE_BUS = 9'h038;
   localparam logic [8:0] ARB_SAMPLE_PRESC = 9'h008;
   localparam int BUS_DIV = 4;
   localparam logic [1:0] BUS_DIV_LAST = 2'(BUS_DIV - 1);

   // ==========================================================================
   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [2:0] RST_IRQ = 3'h0;

   // ==========================================================================
   // Modes and states
   typedef enum logic [1:0] {
      SAC_MODE_IDLE = 2'h0,
      SAC_MODE_MEASURE = 2'h1,
      SAC_MODE_ARB = 2'h2,
      SAC_MODE_RSVD = 2'h3
   } sac_mode_e;

   typedef enum logic [1:0] {
      SAC_ST_WAIT = 2'h0,
      SAC_ST_COUNT = 2'h1,
      SAC_ST_DONE = 2'h3
   } sac_state_e;

   typedef struct packed {
      sac_mode_e mode;
      logic aclk;
   } sac_ctrl_s;

endpackage : sac_pkg

//--- logic/sac_tick_gen.sv
`timescale 1ns/1ps

// ============================================================================
// Counter clock enable: bus clock divided by four, or half the prescaler rate.
module sac_tick_gen
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic clear_in,
   input wire logic aclk_in,
   input wire logic src_sel_in,
   input wire logic bus_tick_in,
   input wire logic xtal_tick_in,
   output logic tick_out
);

   logic [1:0] div_reg;
   logic [1:0] div_next;
   logic half_reg;
   logic half_next;
   logic tick_reg;
   logic tick_next;
   logic presc_tick;

   always_comb
   begin
      presc_tick = src_sel_in ? xtal_tick_in : bus_tick_in;
      div_next = div_reg + 2'h1;
      half_next = half_reg ^ presc_tick;
      if (aclk_in)
      begin
         tick_next = presc_tick & half_reg;
      end
      else
      begin
         tick_next = (div_reg == sac_pkg::BUS_DIV_LAST);
      end
      if (clear_in)
      begin
         div_next = 2'h0;
         half_next = 1'b0;
         tick_next = 1'b0;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         div_reg <= 2'h0;
         half_reg <= 1'b0;
         tick_reg <= 1'b0;
      end
      else
      begin
         div_reg <= div_next;
         half_reg <= half_next;
         tick_reg <= tick_next;
      end
   end

   assign tick_out = tick_reg;

endmodule : sac_tick_gen

//--- testbench/sac_top_chk.sv
`timescale 1ns/1ps

// ==========================================
// Port-level checks of the arbiter counter.
module sac_top_chk
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [3:0] addr_in,
   input wire logic [7:0] wr_data_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic rx_pin_in,
   input wire logic internal_transmit_out_in,
   input wire logic serial_clock_source_select_in,
   input wire logic presc_bus_tick_in,
   input wire logic presc_crystal_tick_in,
   input wire logic [7:0] rd_data_out,
   input wire logic tx_pin_out,
   input wire logic irq_out
);
   default clocking @(posedge clk_in);
   endclocking
   default disable iff (rst_in);
   logic wc;
   logic rc;
   logic rl;
   assign wc = wr_in && addr_in == sac_pkg::ADDR_CTRL;
   assign rc = rd_in && addr_in == sac_pkg::ADDR_CTRL;
   assign rl = rd_in && addr_in == sac_pkg::ADDR_COUNT_LOW;

   AST_RD_ZERO: assert property (!$past(rd_in) |-> rd_data_out == 8'h00)
      else $error("read data not zero outside answer cycle");
   AST_UNMAP: assert property (rd_in && addr_in > 4'h3 |=>
      rd_data_out == 8'h00)
      else $error("unmapped read not zero");
   AST_TX_OR: assert property (internal_transmit_out_in |=>
      tx_pin_out)
      else $error("transmit pin low while internal transmit high");
   AST_LOST_TX: assert property ($past(rc) && rd_data_out[5] |->
      tx_pin_out)
      else $error("transmit pin not forced high while lost");
   AST_MODE_RB: assert property (wc ##1 rc |=>
      rd_data_out[7:6] == $past(wr_data_in[7:6], 2) &&
      rd_data_out[4] == $past(wr_data_in[4], 2))
      else $error("mode or clock select not read back");
   AST_WR_CLR: assert property (wc ##1 rc |=>
      rd_data_out[3] == 1'b0 && rd_data_out[1:0] == 2'h0)
      else $error("flags not cleared by control write");
   AST_LOST_CLR: assert property (wc && !wr_data_in[7] ##1 rc |=>
      !rd_data_out[5])
      else $error("lost flag not cleared");
   AST_CNT_CLR: assert property (wc ##1 rl |=>
      rd_data_out <= 8'h01)
      else $error("count not cleared by control write");
   AST_IDLE_RUN: assert property ($past(rc) &&
      rd_data_out[7] == rd_data_out[6] |-> rd_data_out[2:0] == 3'h0)
      else $error("counter active in idle mode");
endmodule : sac_top_chk

//--- testbench/sac_bus_peer.sv
`timescale 1ns/1ps

// ==========================================
// Far side: shared dominant-low line and prescaler ticks.
module sac_bus_peer
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic dominant_in,
   input wire logic tx_line_in,
   output logic rx_line_out,
   output logic bus_tick_out,
   output logic crystal_tick_out
);
   logic [1:0] ph_reg;
   // The line is pulled up; any party driving low wins.
   assign rx_line_out = tx_line_in & ~dominant_in;
   assign crystal_tick_out = (ph_reg == 2'h2);
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         ph_reg <= 2'h0;
         bus_tick_out <= 1'b0;
      end
      else
      begin
         ph_reg <= (ph_reg == 2'h2) ? 2'h0 : ph_reg + 2'h1;
         bus_tick_out <= ~bus_tick_out;
      end
   end
endmodule : sac_bus_peer

//--- testbench/sac_top_test.sv
`timescale 1ns/1ps

// ==========================================
// Register-level tests of the arbiter counter.
module sac_top_test;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [3:0] addr_in = 4'h0;
   logic [7:0] wr_data_in = 8'h00;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic itx = 1'b0;
   logic src_sel = 1'b0;
   logic dom = 1'b0;
   logic rx;
   logic btick;
   logic xtick;
   logic [7:0] rd_data_out;
   logic tx_pin_out;
   logic irq_out;
   logic [7:0] d;
   int err_count = 0;
   int cmp_count = 0;

   always #50 clk_in = ~clk_in;

   sac_bus_peer u_peer (.clk_in(clk_in), .rst_in(rst_in), .dominant_in(dom),
      .tx_line_in(tx_pin_out), .rx_line_out(rx), .bus_tick_out(btick),
      .crystal_tick_out(xtick));
   sac_top u_dut (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
      .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in),
      .rx_pin_in(rx), .internal_transmit_out_in(itx),
      .serial_clock_source_select_in(src_sel), .presc_bus_tick_in(btick),
      .presc_crystal_tick_in(xtick), .rd_data_out(rd_data_out),
      .tx_pin_out(tx_pin_out), .irq_out(irq_out));

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
   endtask : cyc

   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      // Behind another write, one edge passes with the strobe low.
      if (wr_in)
         @(posedge clk_in);
      wr_in <= 1'b1;
      addr_in <= a;
      wr_data_in <= v;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      rd_in <= 1'b1;
      addr_in <= a;
      @(posedge clk_in);
      rd_in <= 1'b0;
      @(negedge clk_in);
      v = rd_data_out;
      @(posedge clk_in);
   endtask : rd

   task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
      logic [7:0] v;
      rd(a, v);
      chk(v, exp);
   endtask : rdc

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : conclude

   initial
   begin
      cyc(20000);
      err_count++;
      conclude();
   end

   initial
   begin
      cyc(10);
      chk({7'h0, tx_pin_out}, 8'h01);
      rst_in <= 1'b0;
      itx <= 1'b1;
      cyc(2);
      rdc(4'h0, 8'h00);
      rdc(4'h1, 8'h00);
      rdc(4'h2, 8'h00);
      rdc(4'h5, 8'h00);
      wr(4'h0, 8'hFF);
      rdc(4'h0, 8'hD0);
      $display("reset and access test done");
      wr(4'h0, 8'h40);
      cyc(5);
      dom <= 1'b1;
      cyc(20);
      dom <= 1'b0;
      cyc(20);
      dom <= 1'b1;
      cyc(10);
      rdc(4'h0, 8'h48);
      rd(4'h1, d);
      chk({7'h0, d >= 8'h09 && d <= 8'h0B}, 8'h01);
      dom <= 1'b0;
      $display("measurement on bus clock test done");
      for (int s = 0; s < 2; s++)
      begin
         src_sel <= s[0];
         dom <= 1'b1;
         cyc(2);
         wr(4'h0, 8'h50);
         cyc(50);
         rdc(4'h0, 8'h54);
         cyc(48);
         dom <= 1'b0;
         cyc(10);
         rdc(4'h0, 8'h58);
         rd(4'h1, d);
         chk({7'h0, d >= 8'(100 / (4 + 2 * s) - 2) &&
            d <= 8'(100 / (4 + 2 * s) + 4)}, 8'h01);
      end
      $display("measurement on prescaler test done");
      src_sel <= 1'b0;
      wr(4'h2, 8'h07);
      wr(4'h3, 8'h02);
      dom <= 1'b1;
      wr(4'h0, 8'h50);
      cyc(1100);
      rdc(4'h0, 8'h55);
      cyc(998);
      rdc(4'h0, 8'h56);
      chk({7'h0, irq_out}, 8'h01);
      wr(4'h3, 8'h00);
      cyc(2);
      chk({7'h0, irq_out}, 8'h00);
      wr(4'h3, 8'h02);
      cyc(2);
      chk({7'h0, irq_out}, 8'h01);
      wr(4'h2, 8'h02);
      cyc(2);
      chk({7'h0, irq_out}, 8'h00);
      wr(4'h0, 8'h00);
      rdc(4'h1, 8'h00);
      cyc(20);
      rdc(4'h0, 8'h00);
      dom <= 1'b0;
      $display("overflow and interrupt test done");
      itx <= 1'b0;
      wr(4'h2, 8'h07);
      wr(4'h0, 8'h90);
      dom <= 1'b1;
      cyc(2);
      itx <= 1'b1;
      cyc(60);
      rdc(4'h0, 8'hB0);
      rdc(4'h1, 8'h08);
      rdc(4'h2, 8'h04);
      itx <= 1'b0;
      cyc(3);
      chk({7'h0, tx_pin_out}, 8'h01);
      wr(4'h0, 8'h90);
      rdc(4'h0, 8'hB0);
      wr(4'h0, 8'h10);
      rdc(4'h0, 8'h10);
      cyc(2);
      chk({7'h0, tx_pin_out}, 8'h00);
      dom <= 1'b0;
      $display("arbitration lost test done");
      wr(4'h2, 8'h07);
      wr(4'h0, 8'h80);
      cyc(2);
      itx <= 1'b1;
      cyc(20);
      itx <= 1'b0;
      cyc(4);
      rdc(4'h1, 8'h00);
      itx <= 1'b1;
      cyc(100);
      rdc(4'h0, 8'h84);
      cyc(200);
      rdc(4'h0, 8'h80);
      rdc(4'h1, 8'h38);
      rdc(4'h2, 8'h00);
      $display("arbitration won test done");
      rst_in <= 1'b1;
      cyc(2);
      rst_in <= 1'b0;
      cyc(2);
      rdc(4'h0, 8'h00);
      rdc(4'h1, 8'h00);
      rdc(4'h3, 8'h00);
      $display("mid-run reset test done");
      conclude();
   end
endmodule : sac_top_test

bind sac_top sac_top_chk u_chk (.clk_in(clk_in), .rst_in(rst_in),
   .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in),
   .rd_in(rd_in), .rx_pin_in(rx_pin_in),
   .internal_transmit_out_in(internal_transmit_out_in),
   .serial_clock_source_select_in(serial_clock_source_select_in),
   .presc_bus_tick_in(presc_bus_tick_in),
   .presc_crystal_tick_in(presc_crystal_tick_in),
   .rd_data_out(rd_data_out), .tx_pin_out(tx_pin_out), .irq_out(irq_out));
